// [common/pnl_map.vh]
// constants for the front-panel key, lamp, display and line-driver logic
`ifndef PNL_MAP_VH
`define PNL_MAP_VH
// ----------------------------------------------------------------
// clocking
// ----------------------------------------------------------------
`define PNL_CLK_HZ          40000000
`define PNL_OSC_KHZ         7373
`define PNL_BUS_DIV         4
`define PNL_OSC_HALF        3
`define PNL_BUS_HALF        2
// ----------------------------------------------------------------
// reset stretch
// ----------------------------------------------------------------
`define PNL_RST_BUS_CYC     4064
`define PNL_RST_CNT_W       13
// ----------------------------------------------------------------
// key matrix
// ----------------------------------------------------------------
`define PNL_ROWS            8
`define PNL_COLS            8
`define PNL_KEYS            64
`define PNL_ROW_W           3
// ----------------------------------------------------------------
// lamp chain
// ----------------------------------------------------------------
`define PNL_LAMPS           34
`define PNL_LAMP_CNT_W      6
// ----------------------------------------------------------------
// display
// ----------------------------------------------------------------
`define PNL_LCD_W           9
`define PNL_LCD_PHASE       4
`define PNL_FIFO_DEPTH      16
`endif

// [rtl/pnl_fifo.v]
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module pnl_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // drain side
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr & ~do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd & ~do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // pnl_fifo

// [rtl/pnl_panel_io.v]
// front-panel key scan, lamp shifter, display writer and line driver
//
// Operation
// R1: bus clock is the oscillator clock divided by four.
// R2: logic held in reset for 4064 bus-clock cycles after power-up.
// R3: one serial lamp chain lights up to 34 key indicators.
// R4: lamp bit is stable on data line when shift clock rises.
// R5: keys form an eight-row by eight-column matrix of 64.
// R6: a row read decodes three address bits to one low row line.
// R7: all eight rows are read, one read per row.
// R8: column reads low when pressed, high through pull-up otherwise.
// R9: columns appear on data bits, first key on bit zero, low pressed.
// R10: each display write carries one eight-bit character or command.
// R11: register select high for command, low for character data.
// R12: read/write pulses, then latch strobe pulses low to capture byte.
// R13: uart data passes a half-duplex transceiver, released when idle.
// R14: line driver enable high drives the bus, low releases it.
// R15: line driver enable stays low during and right after reset.
// R16: data and register select steady around the latch strobe.
`timescale 1ns/1ps
`include "pnl_map.vh"
module pnl_panel_io (
    // clock and reset
    input  wire                    clk,
    input  wire                    rst,
    // derived clocks and ready flag
    output reg                     system_oscillator_clock,
    output reg                     bus_clock,
    output wire                    logic_ready,
    // key matrix pins
    output reg  [`PNL_ROWS-1:0]    key_matrix_row_line,
    input  wire [`PNL_COLS-1:0]    key_matrix_column_lines,
    // key read port
    input  wire                    key_row_read_select,
    input  wire [`PNL_ROW_W-1:0]   row_address_bits,
    output reg  [`PNL_COLS-1:0]    key_read_data,
    output reg                     key_read_valid,
    output reg  [`PNL_KEYS-1:0]    key_state,
    // lamp load port
    input  wire [`PNL_LAMPS-1:0]   lamp_bits,
    input  wire                    lamp_load,
    output wire                    lamp_busy,
    output reg                     led_serial_data,
    output reg                     led_shift_clock,
    // display write port
    input  wire [7:0]              lcd_byte,
    input  wire                    lcd_is_command,
    input  wire                    lcd_valid,
    output wire                    lcd_ready,
    output reg  [7:0]              display_data,
    output reg                     display_register_select,
    output reg                     display_rw,
    output reg                     display_latch_n,
    // uart line control
    input  wire                    uart_tx_data,
    input  wire                    uart_tx_active,
    output wire                    uart_rx_data,
    output reg                     line_tx_data,
    output reg                     line_driver_enable,
    input  wire                    line_rx_data
);
    // ----------------------------------------------------------------
    // row decode
    // ----------------------------------------------------------------
    function [`PNL_ROWS-1:0] row_decode_n;
        input [`PNL_ROW_W-1:0] sel;
        begin
            row_decode_n      = {`PNL_ROWS{1'b1}};
            row_decode_n[sel] = 1'b0;
        end
    endfunction

    // ----------------------------------------------------------------
    // oscillator and bus clock dividers
    // ----------------------------------------------------------------
    // 40 MHz cannot give 7.3728 MHz exactly; the oscillator image toggles
    // every three clocks and the bus clock is the oscillator divided by 4
    reg [1:0] osc_cnt;
    reg [1:0] bus_cnt;
    reg       bus_rise;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_cnt                 <= 2'h0;
            bus_cnt                 <= 2'h0;
            bus_rise                <= 1'b0;
            system_oscillator_clock <= 1'b0;
            bus_clock               <= 1'b0;
        end else begin
            bus_rise <= 1'b0;
            if (osc_cnt == `PNL_OSC_HALF - 1) begin
                osc_cnt                 <= 2'h0;
                system_oscillator_clock <= ~system_oscillator_clock;
                if (system_oscillator_clock) begin
                    if (bus_cnt == 2'h1) begin // R1
                        bus_cnt   <= 2'h0;
                        bus_clock <= ~bus_clock;
                        bus_rise  <= ~bus_clock;
                    end else begin
                        bus_cnt <= bus_cnt + 2'h1;
                    end
                end
            end else begin
                osc_cnt <= osc_cnt + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // power-up reset stretch
    // ----------------------------------------------------------------
    reg [`PNL_RST_CNT_W-1:0] rst_cnt;
    reg                      run;
    assign logic_ready = run;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rst_cnt <= {`PNL_RST_CNT_W{1'b0}};
            run     <= 1'b0;
        end else if (!run && bus_rise) begin
            if (rst_cnt == `PNL_RST_BUS_CYC - 1) begin // R2
                run <= 1'b1;
            end else begin
                rst_cnt <= rst_cnt + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // key matrix scan
    // ----------------------------------------------------------------
    reg [`PNL_COLS-1:0] col_s1;
    reg [`PNL_COLS-1:0] col_s2;
    reg [`PNL_ROW_W-1:0] rd_row;
    reg [1:0]           rd_stage;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            col_s1              <= {`PNL_COLS{1'b1}};
            col_s2              <= {`PNL_COLS{1'b1}};
            key_matrix_row_line <= {`PNL_ROWS{1'b1}};
            key_read_data       <= {`PNL_COLS{1'b1}};
            key_read_valid      <= 1'b0;
            key_state           <= {`PNL_KEYS{1'b1}};
            rd_row              <= {`PNL_ROW_W{1'b0}};
            rd_stage            <= 2'h0;
        end else begin
            col_s1         <= key_matrix_column_lines; // R8
            col_s2         <= col_s1;
            key_read_valid <= 1'b0;
            if (rd_stage == 2'h0) begin
                if (run && key_row_read_select) begin
                    // R5 R6
                    key_matrix_row_line <= row_decode_n(row_address_bits);
                    rd_row              <= row_address_bits;
                    rd_stage            <= 2'h1;
                end
            end else if (rd_stage == 2'h3) begin
                // wait out the two-stage column synchroniser
                key_read_data  <= col_s2; // R9
                key_read_valid <= 1'b1;
                key_state[rd_row*`PNL_COLS +: `PNL_COLS] <= col_s2; // R7
                key_matrix_row_line <= {`PNL_ROWS{1'b1}};
                rd_stage       <= 2'h0;
            end else begin
                rd_stage <= rd_stage + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // lamp serial shifter
    // ----------------------------------------------------------------
    reg [`PNL_LAMPS-1:0]      lamp_sr;
    reg [`PNL_LAMP_CNT_W-1:0] lamp_cnt;
    reg                       lamp_act;
    assign lamp_busy = lamp_act;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lamp_sr         <= {`PNL_LAMPS{1'b0}};
            lamp_cnt        <= {`PNL_LAMP_CNT_W{1'b0}};
            lamp_act        <= 1'b0;
            led_serial_data <= 1'b0;
            led_shift_clock <= 1'b0;
        end else if (!lamp_act) begin
            led_shift_clock <= 1'b0;
            if (run && lamp_load) begin
                // bit zero goes out at once, ahead of the first rise
                led_serial_data <= lamp_bits[0]; // R4
                lamp_sr  <= {1'b0, lamp_bits[`PNL_LAMPS-1:1]}; // R3
                lamp_cnt <= {`PNL_LAMP_CNT_W{1'b0}};
                lamp_act <= 1'b1;
            end
        end else if (bus_rise) begin
            led_shift_clock <= ~led_shift_clock; // R4
            if (!led_shift_clock) begin
                lamp_cnt <= lamp_cnt + 1'b1;
            end else if (lamp_cnt == `PNL_LAMPS) begin
                lamp_act <= 1'b0;
            end else begin
                // next bit moves as the clock falls, a bus period ahead
                led_serial_data <= lamp_sr[0]; // R4
                lamp_sr         <= {1'b0, lamp_sr[`PNL_LAMPS-1:1]};
            end
        end
    end

    // ----------------------------------------------------------------
    // display write path through a 16-word fifo
    // ----------------------------------------------------------------
    wire [`PNL_LCD_W-1:0] lcd_word;
    wire                  lcd_word_valid;
    reg                   lcd_take;
    pnl_fifo #(
        .WIDTH (`PNL_LCD_W),
        .DEPTH (`PNL_FIFO_DEPTH),
        .AW    (4)
    ) u_lcd_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   ({lcd_is_command, lcd_byte}),
        .in_valid  (lcd_valid & run),
        .in_ready  (lcd_ready),
        .out_data  (lcd_word),
        .out_valid (lcd_word_valid),
        .out_ready (lcd_take)
    );

    localparam [3:0] LS_IDLE  = 4'h1;
    localparam [3:0] LS_SETUP = 4'h2;
    localparam [3:0] LS_RW    = 4'h4;
    localparam [3:0] LS_LATCH = 4'h8;
    reg [3:0] lcd_state;
    reg [1:0] lcd_ph;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lcd_state               <= LS_IDLE;
            lcd_ph                  <= 2'h0;
            lcd_take                <= 1'b0;
            display_data            <= 8'h00;
            display_register_select <= 1'b0;
            display_rw              <= 1'b0;
            display_latch_n         <= 1'b1;
        end else begin
            lcd_take <= 1'b0;
            case (lcd_state)
            LS_IDLE: begin
                if (lcd_word_valid && !lcd_take) begin
                    display_data            <= lcd_word[7:0]; // R10
                    display_register_select <= lcd_word[8];   // R11
                    lcd_take                <= 1'b1;
                    lcd_ph                  <= 2'h0;
                    lcd_state               <= LS_SETUP;
                end
            end
            LS_SETUP: begin
                if (bus_rise) begin
                    display_rw <= 1'b1; // R12
                    lcd_state  <= LS_RW;
                end
            end
            LS_RW: begin
                if (bus_rise) begin
                    display_rw      <= 1'b0;
                    display_latch_n <= 1'b0; // R12
                    lcd_state       <= LS_LATCH;
                end
            end
            LS_LATCH: begin
                if (bus_rise) begin
                    // data held one more bus period after the rising strobe
                    if (lcd_ph == 2'h0) begin
                        display_latch_n <= 1'b1; // R16
                    end
                    lcd_ph <= lcd_ph + 2'h1;
                    if (lcd_ph == 2'h1) begin
                        lcd_state <= LS_IDLE;
                    end
                end
            end
            default: begin
                lcd_state <= LS_IDLE;
            end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // half-duplex line driver
    // ----------------------------------------------------------------
    reg rx_s1;
    reg rx_s2;
    assign uart_rx_data = rx_s2;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_s1              <= 1'b1;
            rx_s2              <= 1'b1;
            line_tx_data       <= 1'b1;
            line_driver_enable <= 1'b0; // R15
        end else begin
            rx_s1              <= line_rx_data;
            rx_s2              <= rx_s1; // R13
            line_tx_data       <= uart_tx_data;
            line_driver_enable <= run & uart_tx_active; // R13 R14
        end
    end
endmodule // pnl_panel_io

// [sim/pnl_io_asserts.sv]
// concurrent checks on the panel io ports
`timescale 1ns/1ps
module pnl_io_asserts (
    // clock and reset
    input logic       clk,
    input logic       rst,
    // watched ports
    input logic       system_oscillator_clock,
    input logic       bus_clock,
    input logic       logic_ready,
    input logic [7:0] key_matrix_row_line,
    input logic       key_read_valid,
    input logic       led_serial_data,
    input logic       led_shift_clock,
    input logic [7:0] display_data,
    input logic       display_register_select,
    input logic       display_rw,
    input logic       display_latch_n,
    input logic       uart_tx_active,
    input logic       line_driver_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_bus_divide: assert property ($rose(bus_clock) |-> ##12 $fell(bus_clock))
        else $error("bus clock half period wrong");
    a_osc_half: assert property ($rose(system_oscillator_clock) |->
        ##3 $fell(system_oscillator_clock))
        else $error("oscillator image half period wrong");
    a_row_single: assert property ($countones(~key_matrix_row_line) <= 1)
        else $error("more than one row driven");
    a_read_row: assert property (key_read_valid |->
        $past(key_matrix_row_line) != 8'hFF && key_matrix_row_line == 8'hFF)
        else $error("read data without a driven row");
    a_read_pulse: assert property (key_read_valid |=> !key_read_valid)
        else $error("read valid longer than one cycle");
    a_lamp_setup: assert property ($rose(led_shift_clock) |-> $stable(led_serial_data))
        else $error("lamp data moved at shift clock rise");
    a_lcd_hold: assert property (!display_latch_n |->
        $stable(display_data) && $stable(display_register_select))
        else $error("display byte moved under latch");
    a_latch_after_rw: assert property ($fell(display_latch_n) |-> $past(display_rw))
        else $error("latch strobe without read write pulse");
    a_drv_idle: assert property (!uart_tx_active |=> !line_driver_enable)
        else $error("line driven while transmitter idle");
    a_drv_reset: assert property (!logic_ready |=> !line_driver_enable)
        else $error("line driven before logic ready");
endmodule // pnl_io_asserts

bind pnl_panel_io pnl_io_asserts u_chk (
    .clk(clk), .rst(rst), .bus_clock(bus_clock), .logic_ready(logic_ready),
    .system_oscillator_clock(system_oscillator_clock),
    .key_matrix_row_line(key_matrix_row_line),
    .key_read_valid(key_read_valid), .led_serial_data(led_serial_data),
    .led_shift_clock(led_shift_clock), .display_data(display_data),
    .display_register_select(display_register_select),
    .display_rw(display_rw), .display_latch_n(display_latch_n),
    .uart_tx_active(uart_tx_active),
    .line_driver_enable(line_driver_enable));

// [sim/pnl_ctrl_model.sv]
// system controller at the far end of the two-wire line
`timescale 1ns/1ps
module pnl_ctrl_model (
    // line side
    input  wire logic line_tx_data,
    input  wire logic line_driver_enable,
    output wire logic line_rx_data,
    // controller side
    input  wire logic reply_bit,
    output wire logic line_level
);
    // the controller only talks while the panel has released the pair
    assign line_level   = line_driver_enable ? line_tx_data : reply_bit;
    assign line_rx_data = line_level;
endmodule // pnl_ctrl_model

// [sim/tb_top.sv]
// self-checking bench for the panel io block
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst, rdy, ksel, kvalid, lload, lbusy, led_d, led_c;
    logic        lcmd, lvalid, lready, rs, rw, latch_n, tx_d, tx_act, rx_d;
    logic        line_tx, line_en, line_rx, reply, level;
    logic [7:0]  rows, cols, kdata, lbyte, ddata;
    logic [7:0]  press [8];
    logic [2:0]  kaddr;
    logic [63:0] kstate;
    logic [33:0] lbits, lcap;
    logic [8:0]  lcd_q [$];
    int          lamp_n, n_mismatch, checks;

    pnl_panel_io DUT (
        .clk(clk), .rst(rst), .system_oscillator_clock(), .bus_clock(),
        .logic_ready(rdy), .key_matrix_row_line(rows),
        .key_matrix_column_lines(cols), .key_row_read_select(ksel),
        .row_address_bits(kaddr), .key_read_data(kdata),
        .key_read_valid(kvalid), .key_state(kstate), .lamp_bits(lbits),
        .lamp_load(lload), .lamp_busy(lbusy), .led_serial_data(led_d),
        .led_shift_clock(led_c), .lcd_byte(lbyte), .lcd_is_command(lcmd),
        .lcd_valid(lvalid), .lcd_ready(lready), .display_data(ddata),
        .display_register_select(rs), .display_rw(rw),
        .display_latch_n(latch_n), .uart_tx_data(tx_d),
        .uart_tx_active(tx_act), .uart_rx_data(rx_d),
        .line_tx_data(line_tx), .line_driver_enable(line_en),
        .line_rx_data(line_rx));

    pnl_ctrl_model u_ctrl (
        .line_tx_data(line_tx), .line_driver_enable(line_en),
        .line_rx_data(line_rx), .reply_bit(reply), .line_level(level));

    // pressed key pulls its column to the driven row, pull-up otherwise
    always @* begin
        cols = 8'hFF;
        for (int r = 0; r < 8; r++)
            if (rows[r] === 1'b0) cols = cols & ~press[r];
    end

    always @(posedge led_c)
        if (lbusy === 1'b1) begin
            if (lamp_n < 34) lcap[lamp_n] = led_d;
            lamp_n++;
        end

    always @(posedge latch_n)
        if (rdy === 1'b1) lcd_q.push_back({rs, ddata});

    task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic results;
        if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic t_keys;
        int r, k;
        logic [63:0] exp;
        for (r = 0; r < 8; r++) begin
            press[r] = (8'h01 << r) | 8'h40;
            exp[8*r +: 8] = ~press[r];
        end
        for (r = 0; r < 8; r++) begin
            ksel = 1;
            kaddr = r[2:0];
            @(negedge clk);
            ksel = 0;
            k = 0;
            while (kvalid !== 1'b1 && k < 10) begin
                @(negedge clk);
                k++;
            end
            chk_vec(kdata, {~press[r]});
        end
        chk_vec(kstate, exp);
        chk_vec(rows, 8'hFF);
    endtask

    task automatic t_lamp;
        int k;
        lamp_n = 0;
        lbits = 34'h2_C3A5_0F96;
        lload = 1;
        @(negedge clk);
        lload = 0;
        chk_bit(lbusy, 1);
        k = 0;
        while (lbusy !== 1'b0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        chk_vec(lamp_n, 34);
        chk_vec(lcap, lbits);
    endtask

    task automatic t_lcd;
        int k, n;
        n = 0;
        lvalid = 1;
        while (lready === 1'b1 && n < 40) begin
            lcmd = n[0];
            lbyte = 8'h41 + n[7:0];
            @(negedge clk);
            n++;
        end
        lvalid = 0;
        chk_bit(n >= 16 && n <= 17, 1);
        k = 0;
        while (lcd_q.size() < n && k < 4000) begin
            @(negedge clk);
            k++;
        end
        chk_bit(lready, 1);
        for (k = 0; k < n; k++)
            chk_vec(lcd_q[k], {k[0], 8'h41 + k[7:0]});
    endtask

    task automatic t_line;
        tx_act = 1;
        tx_d = 0;
        repeat (2) @(negedge clk);
        chk_bit(line_en, 1);
        chk_bit(level, 0);
        tx_d = 1;
        @(negedge clk);
        chk_bit(level, 1);
        tx_act = 0;
        repeat (4) @(negedge clk);
        chk_bit(line_en, 0);
        chk_bit(rx_d, 0);
        reply = 1;
        repeat (3) @(negedge clk);
        chk_bit(rx_d, 1);
    endtask

    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #(105000 * 25);
        n_mismatch++;
        results;
    end

    initial begin
        int k;
        n_mismatch = 0;
        checks = 0;
        {ksel, kaddr, lload, lbits, lbyte, lcmd, lvalid} = '0;
        {tx_d, reply, lamp_n} = '0;
        tx_act = 1;
        for (k = 0; k < 8; k++)
            press[k] = 8'h00;
        rst = 1;
        repeat (3) @(negedge clk);
        chk_bit(line_en, 0);
        rst = 0;
        repeat (96000) @(negedge clk);
        chk_bit(logic_ready_or_zero(), 0);
        chk_bit(line_en, 0);
        k = 0;
        while (rdy !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        chk_bit(rdy, 1);
        tx_act = 0;
        t_keys;
        t_lamp;
        t_lcd;
        t_line;
        results;
    end

    function automatic logic logic_ready_or_zero();
        return rdy;
    endfunction
endmodule // tb_top
